// [rtl/agp_pad_cfg_pkg.sv]
// shared constants and carriers for the graphics-port pad configuration block
// assumes a single 100 MHz core clock and a word-aligned configuration access port
package agp_pad_cfg_pkg;
	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CFG_STATUS = 8'h88;
	localparam logic [7:0] OFS_PORT_STATUS = 8'hA4;
	localparam logic [7:0] OFS_DYN_COMP = 8'hB4;
	localparam logic [7:0] OFS_COMP_BYPASS = 8'hB8;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int STRAP_BIT = 25;
	localparam int FW_EN_BIT = 7;
	localparam int RATE_OVR_BIT = 6;
	localparam int HV_SEL_BIT = 5;
	localparam int BUS_MODE_BIT = 2;
	localparam int PERIODIC_BIT = 1;
	localparam int ONE_SHOT_BIT = 0;
	localparam int PVAL_LSB = 28;
	localparam int NVAL_LSB = 24;
	localparam int XFER_BYP_BIT = 23;
	localparam int STRB_BYP_BIT = 7;
	localparam int PORT_FW_BIT = 4;
	// bypass register bits that hold storage; the rest read as zero
	localparam logic [31:0] BYPASS_RW_MASK = 32'hFF8F_FF8F;

	// ----------------------------------------------------------------
	// reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [31:0] BYPASS_RESET = 32'h0000_0000;
	localparam logic [2:0] RATE_4X = 3'h7;
	localparam logic [2:0] RATE_2X = 3'h3;
	localparam logic [3:0] DRIVE_RESET = 4'h8;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int COMP_SETTLE_NS = 80;
	localparam int COMP_SETTLE_CYCLES = (COMP_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam longint COMP_INTERVAL_MS = 6400;
	localparam longint COMP_INTERVAL_CYCLES_L = COMP_INTERVAL_MS * 64'd1000000 / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} cfg_req_t;

	typedef struct packed {
		logic [3:0] p_drive;
		logic [3:0] n_drive;
		logic [1:0] p_slew;
		logic [1:0] n_slew;
	} pad_drive_t;

	typedef enum logic [2:0] {
		COMP_IDLE = 3'h1,
		COMP_WAIT_IDLE = 3'h2,
		COMP_MEASURE = 3'h4
	} comp_state_t;
endpackage

// [rtl/pad_comp_engine.sv]
// automatic drive-strength compensation for the transfer and strobe pads
// assumes the sense codes from the pad reference are stable and synchronous to i_clk_sys
`timescale 1ns/1ps
`default_nettype none
module pad_comp_engine #(
	parameter int unsigned INTERVAL_CYCLES = 32'(agp_pad_cfg_pkg::COMP_INTERVAL_CYCLES_L)
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_periodic_en,
	input wire logic i_one_shot,
	input wire logic i_port_idle,
	input wire logic [3:0] i_sense_p,
	input wire logic [3:0] i_sense_n,
	output logic [3:0] o_pval,
	output logic [3:0] o_nval,
	output logic o_done
);
	typedef struct packed {
		agp_pad_cfg_pkg::comp_state_t st;
		logic [31:0] interval;
		logic [3:0] settle;
		logic [3:0] pval;
		logic [3:0] nval;
		logic done;
	} eng_state_t;

	eng_state_t s_q;
	eng_state_t s_d;

	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (i_periodic_en && s_q.interval != 32'h0000_0000) begin
			s_d.interval = s_q.interval - 32'h0000_0001;
		end
		case (s_q.st)
			agp_pad_cfg_pkg::COMP_IDLE: begin
				// the one-shot request is still up while done is shown; ignore it then to avoid a second pass
				if (!s_q.done && (i_one_shot || (i_periodic_en && s_q.interval == 32'h0000_0000))) begin
					s_d.interval = INTERVAL_CYCLES;
					s_d.st = agp_pad_cfg_pkg::COMP_WAIT_IDLE;
				end
			end
			agp_pad_cfg_pkg::COMP_WAIT_IDLE: begin
				// only start when the port is quiet
				if (i_port_idle) begin
					s_d.settle = 4'(agp_pad_cfg_pkg::COMP_SETTLE_CYCLES - 1);
					s_d.st = agp_pad_cfg_pkg::COMP_MEASURE;
				end
			end
			agp_pad_cfg_pkg::COMP_MEASURE: begin
				if (s_q.settle != 4'h0) begin
					s_d.settle = s_q.settle - 4'h1;
				end else if (i_port_idle) begin
					s_d.pval = i_sense_p;
					s_d.nval = i_sense_n;
					s_d.done = 1'b1;
					s_d.st = agp_pad_cfg_pkg::COMP_IDLE;
				end else begin
					// traffic started; retry rather than disturb it
					s_d.st = agp_pad_cfg_pkg::COMP_WAIT_IDLE;
				end
			end
			default: begin
				s_d.st = agp_pad_cfg_pkg::COMP_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '{st: agp_pad_cfg_pkg::COMP_IDLE, interval: 32'h0000_0000, settle: 4'h0,
				pval: agp_pad_cfg_pkg::DRIVE_RESET, nval: agp_pad_cfg_pkg::DRIVE_RESET, done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_pval = s_q.pval;
	assign o_nval = s_q.nval;
	assign o_done = s_q.done;

	property p_update_only_idle;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(o_pval != $past(o_pval) || o_nval != $past(o_nval)) |-> $past(i_port_idle);
	endproperty
	a_update_only_idle: assert property (p_update_only_idle) else $error("drive code changed during traffic");

	property p_settle_time;
		@(posedge i_clk_sys) disable iff (!i_rst_n)
		(s_q.st == agp_pad_cfg_pkg::COMP_WAIT_IDLE && i_port_idle) |=> (s_q.st == agp_pad_cfg_pkg::COMP_MEASURE)[*8];
	endproperty
	a_settle_time: assert property (p_settle_time) else $error("measurement window too short");
endmodule
`default_nettype wire

// [rtl/agp_signalling_pad_config.sv]
// graphics-port signalling strap, rate/fast-write reporting and pad compensation settings
// assumes configuration requests are single-cycle pulses, one at a time, answered next cycle
//
// Operation
// - strap level caught after reset, readable at bit 25 of 0x88
// - strap 0 means 1.5-V signalling, 1 means 3.3-V
// - override clear and fast-write set: status shows 4X and fast write
// - override set and fast-write clear: status shows at most 2X, no fast write
// - bypass set: pads take programmed drive values, not compensated ones
// - periodic compensation updates drives at interval; codes are taken only while the port is idle, and the pads follow one cycle later
// - rate override set forces status rate field to 011
`timescale 1ns/1ps
`default_nettype none
module agp_signalling_pad_config #(
	parameter int unsigned COMP_INTERVAL_CYCLES = 32'(agp_pad_cfg_pkg::COMP_INTERVAL_CYCLES_L)
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire agp_pad_cfg_pkg::cfg_req_t i_cfg,
	input wire logic i_signalling_type_strap,
	input wire logic i_port_idle,
	input wire logic [3:0] i_sense_p,
	input wire logic [3:0] i_sense_n,
	output logic [31:0] o_cfg_rdata,
	output logic o_cfg_ack,
	output var agp_pad_cfg_pkg::pad_drive_t o_xfer_pad,
	output var agp_pad_cfg_pkg::pad_drive_t o_strb_pad,
	output logic o_comp_ref_hv,
	output logic o_pci_bus_mode
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic cap_done;
		logic strap;
		logic fw_en;
		logic rate_ovr;
		logic hv_sel;
		logic bus_mode;
		logic periodic;
		logic one_shot;
		logic [31:0] bypass;
		logic [31:0] rdata;
		logic ack;
		agp_pad_cfg_pkg::pad_drive_t xfer_pad;
		agp_pad_cfg_pkg::pad_drive_t strb_pad;
		logic ref_hv;
		logic pci_mode;
	} cfg_state_t;

	cfg_state_t s_q;
	cfg_state_t s_d;
	logic [3:0] eng_pval;
	logic [3:0] eng_nval;
	logic eng_done;
	logic both_bypassed;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] merge_be(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic hits(input agp_pad_cfg_pkg::cfg_req_t r, input logic [7:0] ofs, input logic wr);
		return r.valid && (r.write == wr) && (r.addr == ofs);
	endfunction

	function automatic logic [31:0] dyn_comp_word(input cfg_state_t s, input logic [3:0] pv, input logic [3:0] nv);
		logic [31:0] w;
		w = agp_pad_cfg_pkg::WORD_ZERO;
		w[agp_pad_cfg_pkg::PVAL_LSB +: 4] = pv;
		w[agp_pad_cfg_pkg::NVAL_LSB +: 4] = nv;
		w[agp_pad_cfg_pkg::FW_EN_BIT] = s.fw_en;
		w[agp_pad_cfg_pkg::RATE_OVR_BIT] = s.rate_ovr;
		w[agp_pad_cfg_pkg::HV_SEL_BIT] = s.hv_sel;
		w[agp_pad_cfg_pkg::BUS_MODE_BIT] = s.bus_mode;
		w[agp_pad_cfg_pkg::PERIODIC_BIT] = s.periodic;
		// one-shot reads 1 until its compensation cycle has finished
		w[agp_pad_cfg_pkg::ONE_SHOT_BIT] = s.one_shot;
		return w;
	endfunction

	assign both_bypassed = s_q.bypass[agp_pad_cfg_pkg::XFER_BYP_BIT] && s_q.bypass[agp_pad_cfg_pkg::STRB_BYP_BIT];

	// ----------------------------------------------------------------
	// compensation engine
	// ----------------------------------------------------------------
	pad_comp_engine #(
		.INTERVAL_CYCLES(COMP_INTERVAL_CYCLES)
	) u_comp (
		.i_clk_sys(i_clk_sys),
		.i_rst_n(i_rst_n),
		.i_periodic_en(s_q.periodic && !both_bypassed),
		.i_one_shot(s_q.one_shot && !both_bypassed),
		.i_port_idle(i_port_idle),
		.i_sense_p(i_sense_p),
		.i_sense_n(i_sense_n),
		.o_pval(eng_pval),
		.o_nval(eng_nval),
		.o_done(eng_done)
	);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [31:0] w;
		w = agp_pad_cfg_pkg::WORD_ZERO;
		s_d = s_q;
		s_d.ack = i_cfg.valid;
		s_d.rdata = agp_pad_cfg_pkg::WORD_ZERO;

		// strap is caught on the first edge after reset release
		if (!s_q.cap_done) begin
			s_d.cap_done = 1'b1;
			s_d.strap = i_signalling_type_strap;
		end

		// one-shot finishes on engine done, or at once when both pad sets are bypassed
		if (eng_done || both_bypassed) begin
			s_d.one_shot = 1'b0;
		end

		if (hits(i_cfg, agp_pad_cfg_pkg::OFS_DYN_COMP, 1'b1)) begin
			w = merge_be(dyn_comp_word(s_q, eng_pval, eng_nval), i_cfg.wdata, i_cfg.be);
			s_d.fw_en = w[agp_pad_cfg_pkg::FW_EN_BIT];
			s_d.rate_ovr = w[agp_pad_cfg_pkg::RATE_OVR_BIT];
			s_d.hv_sel = w[agp_pad_cfg_pkg::HV_SEL_BIT];
			s_d.bus_mode = w[agp_pad_cfg_pkg::BUS_MODE_BIT];
			s_d.periodic = w[agp_pad_cfg_pkg::PERIODIC_BIT];
			// a new request wins over a completion in the same cycle
			if (i_cfg.be[0] && i_cfg.wdata[agp_pad_cfg_pkg::ONE_SHOT_BIT]) begin
				s_d.one_shot = 1'b1;
			end
		end
		if (hits(i_cfg, agp_pad_cfg_pkg::OFS_COMP_BYPASS, 1'b1)) begin
			s_d.bypass = merge_be(s_q.bypass, i_cfg.wdata, i_cfg.be) & agp_pad_cfg_pkg::BYPASS_RW_MASK;
		end

		if (i_cfg.valid && !i_cfg.write) begin
			case (i_cfg.addr)
				agp_pad_cfg_pkg::OFS_CFG_STATUS: begin
					s_d.rdata[agp_pad_cfg_pkg::STRAP_BIT] = s_q.strap;
				end
				agp_pad_cfg_pkg::OFS_PORT_STATUS: begin
					// built from live override bits, so no reset is needed
					s_d.rdata[2:0] = s_q.rate_ovr ? agp_pad_cfg_pkg::RATE_2X : agp_pad_cfg_pkg::RATE_4X;
					s_d.rdata[agp_pad_cfg_pkg::PORT_FW_BIT] = s_q.fw_en;
				end
				agp_pad_cfg_pkg::OFS_DYN_COMP: begin
					s_d.rdata = dyn_comp_word(s_q, eng_pval, eng_nval);
				end
				agp_pad_cfg_pkg::OFS_COMP_BYPASS: begin
					s_d.rdata = s_q.bypass;
				end
				default: begin
					s_d.rdata = agp_pad_cfg_pkg::WORD_ZERO;
				end
			endcase
		end

		// pad drive: programmed values under bypass, compensated otherwise
		s_d.xfer_pad.p_drive = s_q.bypass[agp_pad_cfg_pkg::XFER_BYP_BIT] ? s_q.bypass[31:28] : eng_pval;
		s_d.xfer_pad.n_drive = s_q.bypass[agp_pad_cfg_pkg::XFER_BYP_BIT] ? s_q.bypass[27:24] : eng_nval;
		s_d.xfer_pad.p_slew = s_q.bypass[19:18];
		s_d.xfer_pad.n_slew = s_q.bypass[17:16];
		s_d.strb_pad.p_drive = s_q.bypass[agp_pad_cfg_pkg::STRB_BYP_BIT] ? s_q.bypass[15:12] : eng_pval;
		s_d.strb_pad.n_drive = s_q.bypass[agp_pad_cfg_pkg::STRB_BYP_BIT] ? s_q.bypass[11:8] : eng_nval;
		s_d.strb_pad.p_slew = s_q.bypass[3:2];
		s_d.strb_pad.n_slew = s_q.bypass[1:0];
		s_d.ref_hv = s_q.hv_sel;
		s_d.pci_mode = s_q.bus_mode;
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_q <= '{cap_done: 1'b0, strap: 1'b0, fw_en: 1'b0, rate_ovr: 1'b0, hv_sel: 1'b0, bus_mode: 1'b0,
				periodic: 1'b0, one_shot: 1'b0, bypass: agp_pad_cfg_pkg::BYPASS_RESET,
				rdata: agp_pad_cfg_pkg::WORD_ZERO, ack: 1'b0,
				xfer_pad: '{agp_pad_cfg_pkg::DRIVE_RESET, agp_pad_cfg_pkg::DRIVE_RESET, 2'h0, 2'h0},
				strb_pad: '{agp_pad_cfg_pkg::DRIVE_RESET, agp_pad_cfg_pkg::DRIVE_RESET, 2'h0, 2'h0},
				ref_hv: 1'b0, pci_mode: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	assign o_cfg_rdata = s_q.rdata;
	assign o_cfg_ack = s_q.ack;
	assign o_xfer_pad = s_q.xfer_pad;
	assign o_strb_pad = s_q.strb_pad;
	assign o_comp_ref_hv = s_q.ref_hv;
	assign o_pci_bus_mode = s_q.pci_mode;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rst_n);

	property p_strap_capture;
		$rose(s_q.cap_done) |-> s_q.strap == $past(i_signalling_type_strap);
	endproperty
	a_strap_capture: assert property (p_strap_capture) else $error("strap not caught at reset release");

	property p_strap_read;
		(s_q.cap_done && hits(i_cfg, agp_pad_cfg_pkg::OFS_CFG_STATUS, 1'b0)) |=>
			o_cfg_ack && o_cfg_rdata[agp_pad_cfg_pkg::STRAP_BIT] == $past(s_q.strap);
	endproperty
	a_strap_read: assert property (p_strap_read) else $error("strap bit wrong on status read");

	property p_full_rate;
		(hits(i_cfg, agp_pad_cfg_pkg::OFS_PORT_STATUS, 1'b0) && !s_q.rate_ovr && s_q.fw_en) |=>
			o_cfg_rdata[2:0] == agp_pad_cfg_pkg::RATE_4X && o_cfg_rdata[agp_pad_cfg_pkg::PORT_FW_BIT];
	endproperty
	a_full_rate: assert property (p_full_rate) else $error("4X or fast write not reported");

	property p_limited_rate;
		(hits(i_cfg, agp_pad_cfg_pkg::OFS_PORT_STATUS, 1'b0) && s_q.rate_ovr && !s_q.fw_en) |=>
			o_cfg_rdata[2] == 1'b0 && !o_cfg_rdata[agp_pad_cfg_pkg::PORT_FW_BIT];
	endproperty
	a_limited_rate: assert property (p_limited_rate) else $error("rate not limited to 2X");

	property p_override_next_read;
		(hits(i_cfg, agp_pad_cfg_pkg::OFS_DYN_COMP, 1'b1) && i_cfg.be[0] && i_cfg.wdata[agp_pad_cfg_pkg::RATE_OVR_BIT])
			##1 hits(i_cfg, agp_pad_cfg_pkg::OFS_PORT_STATUS, 1'b0) |=> o_cfg_rdata[2:0] == agp_pad_cfg_pkg::RATE_2X;
	endproperty
	a_override_next_read: assert property (p_override_next_read) else $error("override not seen on next read");

	property p_rate_forced;
		(hits(i_cfg, agp_pad_cfg_pkg::OFS_PORT_STATUS, 1'b0) && s_q.rate_ovr) |=> o_cfg_rdata[2:0] == agp_pad_cfg_pkg::RATE_2X;
	endproperty
	a_rate_forced: assert property (p_rate_forced) else $error("rate field not forced to 011");

	property p_xfer_bypass;
		s_q.bypass[agp_pad_cfg_pkg::XFER_BYP_BIT] |=> o_xfer_pad.p_drive == $past(s_q.bypass[31:28])
			&& o_xfer_pad.n_drive == $past(s_q.bypass[27:24]);
	endproperty
	a_xfer_bypass: assert property (p_xfer_bypass) else $error("transfer pads ignore bypass drive");

	property p_strb_bypass;
		s_q.bypass[agp_pad_cfg_pkg::STRB_BYP_BIT] ##1 s_q.bypass[agp_pad_cfg_pkg::STRB_BYP_BIT] |->
			o_strb_pad.p_drive == $past(s_q.bypass[15:12]) && o_strb_pad.n_drive == $past(s_q.bypass[11:8]);
	endproperty
	a_strb_bypass: assert property (p_strb_bypass) else $error("strobe pads ignore bypass drive");

	property p_ack_next;
		i_cfg.valid |=> o_cfg_ack;
	endproperty
	a_ack_next: assert property (p_ack_next) else $error("configuration access not answered");

	c_low_voltage_setup: cover property (s_q.cap_done && !s_q.strap && s_q.fw_en && s_q.bypass[agp_pad_cfg_pkg::STRB_BYP_BIT]);
	c_high_voltage_setup: cover property (s_q.cap_done && s_q.strap && s_q.rate_ovr && !s_q.fw_en);
	c_one_shot_done: cover property (s_q.one_shot ##[1:100] !s_q.one_shot);
endmodule
`default_nettype wire

// [testbench/agp_card_model.sv]
// graphics card stand-in: signalling strap, traffic bursts and pad sense codes
// assumes the bench requests bursts between clock edges
`timescale 1ns/1ps
`default_nettype none
module agp_card_model #(
	parameter int BURST_CYCLES = 20,
	parameter logic [3:0] SENSE_P = 4'h5,
	parameter logic [3:0] SENSE_N = 4'hA
) (
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	input wire logic i_low_voltage,
	input wire logic i_burst,
	output logic o_signalling_type_strap,
	output logic o_port_idle,
	output logic [3:0] o_sense_p,
	output logic [3:0] o_sense_n
);
	int busy_q;
	// 1.5-V cards ground the strap, 3.3-V cards leave it to the pull-up
	assign o_signalling_type_strap = !i_low_voltage;
	assign o_port_idle = (busy_q == 0);
	assign o_sense_p = SENSE_P;
	assign o_sense_n = SENSE_N;
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			busy_q <= 0;
		end else if (i_burst) begin
			busy_q <= BURST_CYCLES;
		end else if (busy_q != 0) begin
			busy_q <= busy_q - 1;
		end
	end
endmodule
`default_nettype wire

// [testbench/tb.sv]
// self-checking bench for the graphics-port pad configuration block
// assumes the card stand-in is compiled alongside; one 100 MHz clock
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [3:0] SP = 4'h5;
	localparam logic [3:0] SN = 4'hA;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	agp_pad_cfg_pkg::cfg_req_t cfg = '0;
	logic low_voltage = 1'b1;
	logic burst = 1'b0;
	logic strap, port_idle, ref_hv, bus_mode, ack;
	logic [3:0] sense_p, sense_n;
	logic [31:0] rdata, rd;
	agp_pad_cfg_pkg::pad_drive_t xfer_pad, strb_pad;
	int mismatches = 0;
	int num_checks = 0;

	initial begin
		forever #5 clk = ~clk;
	end

	agp_card_model #(.SENSE_P(SP), .SENSE_N(SN)) card (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_low_voltage(low_voltage), .i_burst(burst),
		.o_signalling_type_strap(strap), .o_port_idle(port_idle), .o_sense_p(sense_p), .o_sense_n(sense_n)
	);

	// 50-cycle interval; periodic mode stays on too briefly in the run for a periodic pass to happen
	agp_signalling_pad_config #(.COMP_INTERVAL_CYCLES(50)) dut (
		.i_clk_sys(clk), .i_rst_n(rst_n), .i_cfg(cfg), .i_signalling_type_strap(strap),
		.i_port_idle(port_idle), .i_sense_p(sense_p), .i_sense_n(sense_n), .o_cfg_rdata(rdata),
		.o_cfg_ack(ack), .o_xfer_pad(xfer_pad), .o_strb_pad(strb_pad), .o_comp_ref_hv(ref_hv),
		.o_pci_bus_mode(bus_mode)
	);

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// hold keeps valid up so the next access is taken on the very next edge
	task automatic access(input logic w, input logic [7:0] a, input logic [31:0] d, input bit hold = 0);
		cfg <= '{1'b1, w, a, 4'hF, d};
		@(negedge clk);
		check("ack", {31'h0, ack}, 32'h1);
		rd = rdata;
		if (!hold) begin
			cfg.valid <= 1'b0;
			@(negedge clk);
		end
	endtask

	task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		access(1'b0, a, 32'h0);
		check(what, rd & m, e);
	endtask

	task automatic do_reset(input logic low);
		low_voltage <= low;
		rst_n <= 1'b0;
		repeat (4) @(negedge clk);
		rst_n <= 1'b1;
		repeat (2) @(negedge clk);
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset_values();
		do_reset(1'b1);
		rd_chk("strap 1v5", agp_pad_cfg_pkg::OFS_CFG_STATUS, 32'h0200_0000, 32'h0);
		rd_chk("status rst", agp_pad_cfg_pkg::OFS_PORT_STATUS, '1, 32'h7);
		rd_chk("comp rst", agp_pad_cfg_pkg::OFS_DYN_COMP, '1, 32'h8800_0000);
		rd_chk("bypass rst", agp_pad_cfg_pkg::OFS_COMP_BYPASS, '1, agp_pad_cfg_pkg::BYPASS_RESET);
		check("xfer rst", {20'h0, xfer_pad}, 32'h880);
		access(1'b1, agp_pad_cfg_pkg::OFS_PORT_STATUS, 32'hFFFF_FFFF);
		rd_chk("status ro", agp_pad_cfg_pkg::OFS_PORT_STATUS, '1, 32'h7);
		access(1'b1, 8'h90, 32'hFFFF_FFFF);
		rd_chk("unmapped", 8'h90, '1, 32'h0);
		$display("test reset_values done");
	endtask

	task automatic t_rate_report();
		for (int i = 0; i < 4; i++) begin
			access(1'b1, agp_pad_cfg_pkg::OFS_DYN_COMP, {24'h0, i[0], i[1], 6'h0}, 1'b1);
			access(1'b0, agp_pad_cfg_pkg::OFS_PORT_STATUS, 32'h0);
			check("rate", rd, {27'h0, i[0], 1'b0, i[1] ? agp_pad_cfg_pkg::RATE_2X : agp_pad_cfg_pkg::RATE_4X});
		end
		access(1'b1, agp_pad_cfg_pkg::OFS_DYN_COMP, 32'h24);
		check("ref hv", {31'h0, ref_hv}, 32'h1);
		check("bus mode", {31'h0, bus_mode}, 32'h1);
		access(1'b1, agp_pad_cfg_pkg::OFS_DYN_COMP, 32'h0);
		$display("test rate_report done");
	endtask

	task automatic t_comp_traffic();
		int n;
		burst <= 1'b1;
		@(negedge clk);
		burst <= 1'b0;
		access(1'b1, agp_pad_cfg_pkg::OFS_DYN_COMP, 32'h1);
		repeat (8) @(negedge clk);
		// port still busy here, so the old codes must stand
		rd_chk("comp held", agp_pad_cfg_pkg::OFS_DYN_COMP, 32'hFF00_0001, 32'h8800_0001);
		check("xfer held", {20'h0, xfer_pad}, 32'h880);
		n = 0;
		do begin
			access(1'b0, agp_pad_cfg_pkg::OFS_DYN_COMP, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 40);
		check("comp codes", rd & 32'hFF00_0001, {SP, SN, 24'h0});
		check("xfer comp", {20'h0, xfer_pad}, {20'h0, SP, SN, 4'h0});
		check("strb comp", {20'h0, strb_pad}, {20'h0, SP, SN, 4'h0});
		$display("test comp_traffic done");
	endtask

	task automatic t_config_1v5();
		rd_chk("strap 1v5", agp_pad_cfg_pkg::OFS_CFG_STATUS, 32'h0200_0000, 32'h0);
		access(1'b1, agp_pad_cfg_pkg::OFS_DYN_COMP, 32'h82);
		access(1'b1, agp_pad_cfg_pkg::OFS_COMP_BYPASS, 32'h000F_FF8F);
		rd_chk("status 1v5", agp_pad_cfg_pkg::OFS_PORT_STATUS, '1, 32'h17);
		rd_chk("bypass 1v5", agp_pad_cfg_pkg::OFS_COMP_BYPASS, '1, 32'h000F_FF8F);
		check("strb 1v5", {20'h0, strb_pad}, 32'hFFF);
		check("xfer 1v5", {20'h0, xfer_pad}, {20'h0, SP, SN, 4'hF});
		$display("test config_1v5 done");
	endtask

	task automatic t_config_3v3();
		do_reset(1'b0);
		rd_chk("strap 3v3", agp_pad_cfg_pkg::OFS_CFG_STATUS, 32'h0200_0000, 32'h0200_0000);
		access(1'b1, agp_pad_cfg_pkg::OFS_COMP_BYPASS, 32'hFFFF_FFFF);
		rd_chk("bypass mask", agp_pad_cfg_pkg::OFS_COMP_BYPASS, '1, agp_pad_cfg_pkg::BYPASS_RW_MASK);
		check("xfer byp", {20'h0, xfer_pad}, 32'hFFF);
		access(1'b1, agp_pad_cfg_pkg::OFS_DYN_COMP, 32'h40);
		access(1'b1, agp_pad_cfg_pkg::OFS_COMP_BYPASS, 32'h000F_000F);
		rd_chk("status 3v3", agp_pad_cfg_pkg::OFS_PORT_STATUS, '1, 32'h3);
		check("strb 3v3", {20'h0, strb_pad}, 32'h88F);
		$display("test config_3v3 done");
	endtask

	// ----------------------------------------------------------------
	// verdict and main sequence
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		mismatches++;
		$display("watchdog expired");
		conclude();
	end

	initial begin
		t_reset_values();
		t_rate_report();
		t_comp_traffic();
		t_config_1v5();
		t_config_3v3();
		conclude();
	end
endmodule
`default_nettype wire
